/* rtl/lsh_pkg.sv */
// Shared constants and bus carriers for the LIN slave header and auto-synch block
package lsh_pkg;

    // Register byte offsets
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_STAT      = 8'h04;
    localparam logic [7:0]  REG_DATA      = 8'h08;
    localparam logic [7:0]  REG_DIV       = 8'h0C;
    localparam logic [7:0]  REG_PRESC     = 8'h10;
    localparam logic [7:0]  REG_HLEN      = 8'h14;

    // Control register bit positions
    localparam int unsigned CTRL_LIN_EN   = 0;
    localparam int unsigned CTRL_SLAVE    = 1;
    localparam int unsigned CTRL_ASE      = 2;
    localparam int unsigned CTRL_HDM      = 3;
    localparam int unsigned CTRL_MUTE     = 4;
    localparam int unsigned CTRL_DUM      = 5;
    localparam int unsigned CTRL_SFS      = 6;

    // Status register bit positions
    localparam int unsigned STAT_HE       = 0;
    localparam int unsigned STAT_FE       = 1;
    localparam int unsigned STAT_HDF      = 2;
    localparam int unsigned STAT_PE       = 3;
    localparam int unsigned STAT_RXRDY    = 4;

    // Reset values
    localparam logic [11:0] DIV_RST       = 12'h190;
    localparam logic [7:0]  PRESC_RST     = 8'h01;

    // Timing counts
    localparam logic [3:0]  OVS_LAST      = 4'hF;
    localparam logic [3:0]  SMP_FIRST     = 4'h7;
    localparam logic [3:0]  SMP_LAST      = 4'h9;
    localparam logic [11:0] DIV_MIN       = 12'h010;
    localparam logic [12:0] ACC_STEP      = 13'h0010;
    localparam logic [7:0]  BRK_BITS      = 8'h0B;
    localparam logic [7:0]  BRK_TICKS     = 8'hB0;
    localparam logic [7:0]  HDR_MAX_BITS  = 8'h39;
    localparam logic [2:0]  SYNCH_EDGES   = 3'h4;
    localparam logic [14:0] MEAS_MAX      = 15'h7FFF;
    localparam logic [7:0]  SYNCH_BYTE    = 8'h55;

    // APB request and answer
    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } lsh_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } lsh_apb_rsp_s;

endpackage

/* rtl/lsh_top.sv */
// LIN slave receiver with header supervision, auto-synch and fractional baud generator
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module lsh_top
    import lsh_pkg::*;
(
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          reset_n,
    // APB slave
    input  wire lsh_apb_req_s  apb_req,
    output lsh_apb_rsp_s       apb_rsp,
    // LIN receive line from the transceiver
    input  wire logic          receive_input_pin,
    // Rate enables for the transmitter
    output logic               sample_tick,
    output logic               bit_tick
);

    typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_STOP, R_WAITHI} lsh_rx_e;
    typedef enum logic [2:0] {HS_SEARCH, HS_BREAK, HS_SYNCH, HS_SCHAR, HS_ID, HS_BLOCK} lsh_hdr_e;

    // Majority of three samples
    function automatic logic maj3(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    // Synch deviation beyond 15.625 percent of the active divider
    function automatic logic dev_bad(input logic [11:0] act, input logic [11:0] mv);
        logic [13:0] tol;
        tol = {2'b00, act >> 3} + {2'b00, act >> 5};
        return ({2'b00, mv} > ({2'b00, act} + tol)) || (({2'b00, mv} + tol) < {2'b00, act});
    endfunction

    // Identifier protection bits check
    function automatic logic id_par_bad(input logic [7:0] d);
        return (d[6] != (d[0] ^ d[1] ^ d[2] ^ d[4])) || (d[7] != ~(d[1] ^ d[3] ^ d[4] ^ d[5]));
    endfunction

    // State and register declarations
    logic          rx_s1_ff, rx_s2_ff, rx_d_ff;
    logic [12:0]   acc_ff, nxt_acc;
    logic          st_ff, bt_ff;
    logic [3:0]    bph_ff;
    lsh_rx_e       rx_st_ff, nxt_rx_st;
    logic [3:0]    ph_ff, nxt_ph;
    logic [2:0]    smp_ff, nxt_smp;
    logic [2:0]    bcnt_ff, nxt_bcnt;
    logic [7:0]    shf_ff, nxt_shf;
    logic [7:0]    low_ff;
    lsh_hdr_e      hs_ff, nxt_hs;
    logic [2:0]    edges_ff, nxt_edges;
    logic [14:0]   meas_ff, nxt_meas;
    logic          run_ff, nxt_run;
    logic [7:0]    hcnt_ff, nxt_hcnt;
    logic          he_set, id_done, meas_load, sfs_set, sfs_hw_clr, hlen_latch;
    logic          lin_en_ff, slave_ff, ase_ff, hdm_ff, mute_ff, dum_ff, sfs_ff;
    logic [11:0]   nominal_ff, active_ff, measured_ff;
    logic [7:0]    presc_ff, hlen_ff, rx_data_ff;
    logic          he_ff, fe_ff, hdf_ff, pe_ff, rxrdy_ff;
    lsh_apb_rsp_s  apb_rsp_ff;
    logic [31:0]   rd_val;

    // APB decode
    wire           bus_setup   = apb_req.psel & ~apb_req.penable;
    wire           bus_acc     = apb_req.psel & apb_req.penable & apb_rsp_ff.pready;
    wire           bus_wr      = bus_acc & apb_req.pwrite;
    wire           hit_ctrl    = apb_req.paddr == REG_CTRL;
    wire           hit_stat    = apb_req.paddr == REG_STAT;
    wire           hit_data    = apb_req.paddr == REG_DATA;
    wire           hit_div     = apb_req.paddr == REG_DIV;
    wire           hit_presc   = apb_req.paddr == REG_PRESC;
    wire           hit_hlen    = apb_req.paddr == REG_HLEN;
    wire           hit_any     = hit_ctrl | hit_stat | hit_data | hit_div | hit_presc | hit_hlen;
    wire           ctrl_wr     = bus_wr & hit_ctrl;
    wire           stat_wr     = bus_wr & hit_stat;
    wire           nom_wr      = bus_wr & hit_div;
    wire           data_rd     = bus_acc & ~apb_req.pwrite & hit_data;
    wire [31:0]    wd          = apb_req.pwdata;

    // Mode selection and divider source
    wire           slave_mode  = lin_en_ff & slave_ff;
    wire [11:0]    div_raw     = slave_mode ? active_ff : {presc_ff, 4'h0};
    wire [11:0]    div_use     = (div_raw < DIV_MIN) ? DIV_MIN : div_raw;
    wire [12:0]    acc_sum     = acc_ff + ACC_STEP;
    wire           st_hit      = acc_sum >= {1'b0, div_use};

    // Line conditioning and edges
    wire           rx_s        = rx_s2_ff;
    wire           fall        = rx_d_ff & ~rx_s;
    wire           brk_det     = st_ff & ~rx_s & (low_ff == BRK_TICKS - 8'h01);
    wire           brk_end     = rx_s & (low_ff == BRK_TICKS);

    // Character receiver decode
    wire           rx_halt     = (hs_ff == HS_SYNCH) | (hs_ff == HS_BLOCK);
    wire           bit_val     = maj3(smp_ff);
    wire           char_done   = st_ff & ~rx_halt & (rx_st_ff == R_STOP) & (ph_ff == OVS_LAST)
                                 & (bit_val | (|shf_ff));
    wire           char_fe     = ~bit_val;

    // Header decode
    wire           hdr_watch   = hdm_ff | ase_ff;
    wire           tmo         = run_ff & hdr_watch & (hcnt_ff > HDR_MAX_BITS);
    wire           sfs_sw_clr  = ctrl_wr & ~wd[CTRL_SFS] & sfs_ff;
    wire           id_ok       = id_done & ~char_fe;
    wire           wake        = slave_mode & mute_ff & (hdm_ff ? id_ok : brk_det);
    wire           hdf_set     = slave_mode & (hdm_ff ? id_ok : brk_det);
    wire           pe_set      = id_done & id_par_bad(shf_ff);
    wire           hdr_eats    = slave_mode & hdm_ff & ((hs_ff == HS_SCHAR) | (hs_ff == HS_ID));
    wire           dlv_norm    = char_done & ~mute_ff & ~hdr_eats;
    wire           dlv_id      = id_done & hdm_ff & (~mute_ff | ~char_fe);
    wire           dlv_brk     = brk_det & slave_mode & ~hdm_ff;
    wire           deliver     = dlv_norm | dlv_id | dlv_brk;
    wire           fe_set      = char_done & char_fe & ~mute_ff;
    wire [11:0]    meas_div    = meas_ff[14:3];

    // Fractional baud accumulator, one sample tick per div_use/16 clocks
    always_comb
    begin
        nxt_acc = st_hit ? acc_sum - {1'b0, div_use} : acc_sum;
    end

    // Synchroniser, baud ticks and break low counter
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
            rx_d_ff  <= 1'b1;
            acc_ff   <= '0;
            st_ff    <= 1'b0;
            bt_ff    <= 1'b0;
            bph_ff   <= '0;
            low_ff   <= '0;
        end
        else
        begin
            rx_s1_ff <= receive_input_pin;
            rx_s2_ff <= rx_s1_ff;
            rx_d_ff  <= rx_s2_ff;
            acc_ff   <= nxt_acc;
            st_ff    <= st_hit;
            bt_ff    <= st_hit & (bph_ff == OVS_LAST);
            bph_ff   <= st_hit ? bph_ff + 4'h1 : bph_ff;
            if (rx_s)
                low_ff <= '0;
            else if (st_ff && low_ff != BRK_TICKS)
                low_ff <= low_ff + 8'h01;
        end
    end

    // Character receiver, 16x oversampled
    always_comb
    begin
        nxt_rx_st = rx_st_ff;
        nxt_ph    = ph_ff;
        nxt_smp   = smp_ff;
        nxt_bcnt  = bcnt_ff;
        nxt_shf   = shf_ff;
        if (rx_halt)
            nxt_rx_st = R_WAITHI;
        else if (st_ff)
        begin
            case (rx_st_ff)
                R_IDLE:
                begin
                    if (!rx_s)
                    begin
                        nxt_rx_st = R_START;
                        nxt_ph    = '0;
                    end
                end
                R_WAITHI:
                begin
                    if (rx_s)
                        nxt_rx_st = R_IDLE;
                end
                R_START, R_DATA, R_STOP:
                begin
                    nxt_ph = ph_ff + 4'h1;
                    if (ph_ff >= SMP_FIRST && ph_ff <= SMP_LAST)
                        nxt_smp = {smp_ff[1:0], rx_s};
                    if (ph_ff == OVS_LAST)
                    begin
                        if (rx_st_ff == R_START)
                        begin
                            nxt_rx_st = bit_val ? R_IDLE : R_DATA;
                            nxt_bcnt  = '0;
                        end
                        else if (rx_st_ff == R_DATA)
                        begin
                            nxt_shf  = {bit_val, shf_ff[7:1]};
                            nxt_bcnt = bcnt_ff + 3'h1;
                            if (bcnt_ff == 3'h7)
                                nxt_rx_st = R_STOP;
                        end
                        else
                            nxt_rx_st = bit_val ? R_IDLE : R_WAITHI;
                    end
                end
                default: nxt_rx_st = R_IDLE;
            endcase
        end
    end

    // Header supervision, synch measurement and time-out
    always_comb
    begin
        nxt_hs     = hs_ff;
        nxt_edges  = edges_ff;
        nxt_meas   = meas_ff;
        nxt_run    = run_ff;
        nxt_hcnt   = hcnt_ff;
        he_set     = 1'b0;
        id_done    = 1'b0;
        meas_load  = 1'b0;
        sfs_set    = 1'b0;
        sfs_hw_clr = 1'b0;
        hlen_latch = 1'b0;
        if (bt_ff && run_ff && hcnt_ff != 8'hFF)
            nxt_hcnt = hcnt_ff + 8'h01;
        if (!slave_mode)
        begin
            nxt_hs  = HS_SEARCH;
            nxt_run = 1'b0;
        end
        else if (brk_det && hs_ff != HS_BLOCK)
        begin
            nxt_hs   = HS_BREAK;
            nxt_run  = 1'b1;
            nxt_hcnt = BRK_BITS;
        end
        else if (tmo)
        begin
            he_set     = 1'b1;
            hlen_latch = 1'b1;
            nxt_run    = 1'b0;
            nxt_hs     = (hs_ff == HS_SYNCH) ? HS_BLOCK : HS_SEARCH;
        end
        else if (sfs_sw_clr && (hs_ff == HS_SYNCH || hs_ff == HS_BLOCK))
        begin
            nxt_hs  = HS_SEARCH;
            nxt_run = 1'b0;
        end
        else
        begin
            case (hs_ff)
                HS_BREAK:
                begin
                    if (brk_end)
                    begin
                        nxt_hs    = ase_ff ? HS_SYNCH : HS_SCHAR;
                        nxt_edges = '0;
                        sfs_set   = ase_ff;
                    end
                end
                HS_SYNCH:
                begin
                    // Count every cycle from the first fall, edge cycles included
                    if (edges_ff != '0 && meas_ff != MEAS_MAX)
                        nxt_meas = meas_ff + 15'h0001;
                    if (fall)
                    begin
                        nxt_edges = edges_ff + 3'h1;
                        if (edges_ff == '0)
                            nxt_meas = 15'h0001;
                        else if (edges_ff == SYNCH_EDGES)
                        begin
                            nxt_edges = '0;
                            if (meas_ff == MEAS_MAX || dev_bad(active_ff, meas_div))
                            begin
                                he_set  = 1'b1;
                                nxt_run = 1'b0;
                                nxt_hs  = HS_BLOCK;
                            end
                            else
                            begin
                                meas_load  = 1'b1;
                                sfs_hw_clr = 1'b1;
                                nxt_hs     = HS_ID;
                            end
                        end
                    end
                end
                HS_SCHAR:
                begin
                    if (char_done)
                    begin
                        if (shf_ff != SYNCH_BYTE)
                        begin
                            he_set  = 1'b1;
                            nxt_run = 1'b0;
                            nxt_hs  = HS_SEARCH;
                        end
                        else
                            nxt_hs = HS_ID;
                    end
                end
                HS_ID:
                begin
                    if (char_done)
                    begin
                        id_done    = 1'b1;
                        hlen_latch = 1'b1;
                        nxt_run    = 1'b0;
                        nxt_hs     = HS_SEARCH;
                    end
                end
                default: ;
            endcase
        end
    end

    // Receiver and header state registers
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_st_ff <= R_IDLE;
            ph_ff    <= '0;
            smp_ff   <= '0;
            bcnt_ff  <= '0;
            shf_ff   <= '0;
            hs_ff    <= HS_SEARCH;
            edges_ff <= '0;
            meas_ff  <= '0;
            run_ff   <= 1'b0;
            hcnt_ff  <= '0;
        end
        else
        begin
            rx_st_ff <= nxt_rx_st;
            ph_ff    <= nxt_ph;
            smp_ff   <= nxt_smp;
            bcnt_ff  <= nxt_bcnt;
            shf_ff   <= nxt_shf;
            hs_ff    <= nxt_hs;
            edges_ff <= nxt_edges;
            meas_ff  <= nxt_meas;
            run_ff   <= nxt_run;
            hcnt_ff  <= nxt_hcnt;
        end
    end

    // Divider copies: nominal, measured, active
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            nominal_ff  <= DIV_RST;
            active_ff   <= DIV_RST;
            measured_ff <= DIV_RST;
        end
        else
        begin
            if (nom_wr)
                nominal_ff <= wd[11:0];
            if (meas_load)
                measured_ff <= meas_div;
            if (nom_wr && !dum_ff)
                active_ff <= wd[11:0];
            else if (meas_load)
                active_ff <= meas_div;
            else if (deliver && dum_ff)
                active_ff <= nominal_ff;
        end
    end

    // Control bits
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lin_en_ff <= 1'b0;
            slave_ff  <= 1'b0;
            ase_ff    <= 1'b0;
            hdm_ff    <= 1'b0;
            mute_ff   <= 1'b0;
            dum_ff    <= 1'b0;
            sfs_ff    <= 1'b0;
            presc_ff  <= PRESC_RST;
        end
        else
        begin
            if (ctrl_wr)
            begin
                lin_en_ff <= wd[CTRL_LIN_EN];
                slave_ff  <= wd[CTRL_SLAVE];
                ase_ff    <= wd[CTRL_ASE];
                hdm_ff    <= wd[CTRL_HDM];
            end
            if (wake)
                mute_ff <= 1'b0;
            else if (ctrl_wr && !(slave_mode && rxrdy_ff))
                mute_ff <= wd[CTRL_MUTE];
            if (deliver && dum_ff)
                dum_ff <= 1'b0;
            else if (ctrl_wr)
                dum_ff <= wd[CTRL_DUM];
            sfs_ff <= sfs_set | (sfs_ff & ~sfs_sw_clr & ~sfs_hw_clr);
            if (bus_wr && hit_presc)
                presc_ff <= wd[7:0];
        end
    end

    // Status flags and received data, set beats clear
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            he_ff      <= 1'b0;
            fe_ff      <= 1'b0;
            hdf_ff     <= 1'b0;
            pe_ff      <= 1'b0;
            rxrdy_ff   <= 1'b0;
            rx_data_ff <= '0;
            hlen_ff    <= '0;
        end
        else
        begin
            he_ff    <= he_set | (he_ff & ~(stat_wr & wd[STAT_HE]));
            fe_ff    <= fe_set | (fe_ff & ~(stat_wr & wd[STAT_FE]));
            hdf_ff   <= hdf_set | (hdf_ff & ~(stat_wr & wd[STAT_HDF]));
            pe_ff    <= pe_set | (pe_ff & ~(stat_wr & wd[STAT_PE]));
            rxrdy_ff <= deliver | (rxrdy_ff & ~data_rd);
            if (deliver)
                rx_data_ff <= dlv_brk ? 8'h00 : shf_ff;
            if (hlen_latch)
                hlen_ff <= hcnt_ff;
        end
    end

    // Read data selection
    always_comb
    begin
        rd_val = '0;
        case (1'b1)
            hit_ctrl:  rd_val = {25'h0, sfs_ff, dum_ff, mute_ff, hdm_ff, ase_ff, slave_ff,
                                 lin_en_ff};
            hit_stat:  rd_val = {27'h0, rxrdy_ff, pe_ff, hdf_ff, fe_ff, he_ff};
            hit_data:  rd_val = {24'h0, rx_data_ff};
            hit_div:   rd_val = {20'h0, active_ff};
            hit_presc: rd_val = {24'h0, presc_ff};
            hit_hlen:  rd_val = {24'h0, hdr_watch ? hlen_ff : 8'h00};
            default:   rd_val = '0;
        endcase
    end

    // APB answer: zero wait states, read data captured in setup
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            apb_rsp_ff <= '0;
        else
        begin
            apb_rsp_ff.pready  <= bus_setup;
            apb_rsp_ff.pslverr <= bus_setup & ~hit_any;
            if (bus_setup)
                apb_rsp_ff.prdata <= rd_val;
        end
    end

    // Outputs from flip-flops
    assign apb_rsp     = apb_rsp_ff;
    assign sample_tick = st_ff;
    assign bit_tick    = bt_ff;

endmodule // lsh_top

/* sim/lsh_lin_master.sv */
// Behavioural LIN master node on the receive line
`timescale 1ns/1ns
module lsh_lin_master
(
    // Clock
    input  wire logic clk_sys,
    // Bus line, recessive high
    output logic      lin_line
);
    int bit_clk = 256; // Clocks per master bit
    initial lin_line = 1'b1;
    // Hold a level for whole bit times
    task automatic send_bits(input logic v, input int n);
        lin_line <= v;
        repeat (n * bit_clk) @(posedge clk_sys);
    endtask
    // One character, LSB first, stop level chosen
    task automatic send_char(input logic [7:0] b, input logic stp);
        send_bits(1'b0, 1);
        for (int i = 0; i < 8; i++)
            send_bits(b[i], 1);
        send_bits(stp, 1);
    endtask
    // Break, delimiter, synch byte, identifier
    task automatic send_header(input logic [7:0] id);
        send_bits(1'b0, 13);
        send_bits(1'b1, 1);
        send_char(8'h55, 1'b1);
        send_char(id, 1'b1);
    endtask
endmodule // lsh_lin_master

/* sim/lsh_top_props.sv */
// Port checker for the LIN slave header block
`timescale 1ns/1ns
module lsh_top_props
    import lsh_pkg::*;
(
    // Clock and reset
    input wire logic         clk_sys,
    input wire logic         reset_n,
    // Register bus
    input wire lsh_apb_req_s apb_req,
    input wire lsh_apb_rsp_s apb_rsp,
    // Line and rate enables
    input wire logic         receive_input_pin,
    input wire logic         sample_tick,
    input wire logic         bit_tick
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Setup cycle and address decode
    wire setup  = apb_req.psel && !apb_req.penable;
    wire mapped = apb_req.paddr inside {REG_CTRL, REG_STAT, REG_DATA, REG_DIV,
                                        REG_PRESC, REG_HLEN};
    a_ready_after_setup: assert property (setup |=> apb_rsp.pready)
        else $error("pready missing");
    a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready too long");
    a_ready_in_access: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
        else $error("pready outside access");
    a_err_with_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("pslverr alone");
    a_err_unmapped: assert property (setup && !mapped |=> apb_rsp.pslverr)
        else $error("pslverr missing");
    a_ok_mapped: assert property (setup && mapped |=> !apb_rsp.pslverr)
        else $error("pslverr on mapped");
    a_err_data_zero: assert property (apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0)
        else $error("prdata on error");
    a_data_hold: assert property (!setup |=> $stable(apb_rsp.prdata))
        else $error("prdata moved");
    a_bit_spacing: assert property (bit_tick |=> !bit_tick [*8])
        else $error("bit_tick too close");
    // Main scenarios
    c_unmapped: cover property (setup && !mapped);
    c_bit: cover property (bit_tick);
    c_hlen: cover property (setup && apb_req.paddr == REG_HLEN);
endmodule // lsh_top_props
bind lsh_top lsh_top_props u_lsh_top_props (.clk_sys(clk_sys), .reset_n(reset_n),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .receive_input_pin(receive_input_pin),
    .sample_tick(sample_tick), .bit_tick(bit_tick));

/* sim/lsh_top_tb_top.sv */
// Self-checking bench for the LIN slave header block
`timescale 1ns/1ns
module lsh_top_tb_top
    import lsh_pkg::*;
;
    logic         clk_sys = 1'b0;
    logic         reset_n = 1'b0;
    lsh_apb_req_s apb_req = '0;
    lsh_apb_rsp_s apb_rsp;
    logic         lin_line;
    logic [31:0]  rd;
    logic         err;
    logic         st;
    logic         bt;
    int           n_mismatch = 0;
    int           checked = 0;
    int           n_st = 0;
    int           n_bt = 0;
    int           s0;
    int           b0;
    // Design and master node
    lsh_top u_lsh_top (.clk_sys(clk_sys), .reset_n(reset_n), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .receive_input_pin(lin_line), .sample_tick(st), .bit_tick(bt));
    lsh_lin_master u_lsh_lin_master (.clk_sys(clk_sys), .lin_line(lin_line));
    initial forever #10 clk_sys = ~clk_sys;
    // Rate enable counters, updated after the edge so reads see settled counts
    always @(posedge clk_sys)
    begin
        if (st)
            n_st <= n_st + 1;
        if (bt)
            n_bt <= n_bt + 1;
    end
    // Verdict
    task automatic report_and_stop();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Compare one word
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    // APB transfer held until pready is sampled
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Read and compare
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string s);
        apb(a, 1'b0, 32'h0);
        chk(s, e, rd);
        chk({s, " error"}, 32'h0, {31'h0, err});
    endtask
    // Wait slave bit times at divider 256
    task automatic bits(input int n);
        repeat (n * 256) @(posedge clk_sys);
    endtask
    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rdc(REG_DIV, 32'h190, "div reset");
        rdc(REG_HLEN, 32'h0, "hlen gated");
        apb(8'h20, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(REG_DIV, 1'b1, 32'h100);
        rdc(REG_DIV, 32'h100, "div write");
        apb(REG_CTRL, 1'b1, 32'h1F);
        bits(2);
        u_lsh_lin_master.send_char(8'h00, 1'b0);
        u_lsh_lin_master.send_bits(1'b1, 2);
        u_lsh_lin_master.send_char(8'h0F, 1'b0);
        u_lsh_lin_master.send_bits(1'b1, 2);
        rdc(REG_STAT, 32'h0, "mute bad char");
        rdc(REG_CTRL, 32'h1F, "no false break");
        u_lsh_lin_master.bit_clk = 264;
        u_lsh_lin_master.send_header(8'h83);
        bits(2);
        rdc(REG_STAT, 32'h1C, "header stat");
        rdc(REG_CTRL, 32'h0F, "woken ctrl");
        rdc(REG_DATA, 32'h83, "identifier");
        apb(REG_DIV, 1'b0, 32'h0);
        chk("measured div", 32'h1, {31'h0, rd inside {[32'h107:32'h109]}});
        apb(REG_HLEN, 1'b0, 32'h0);
        chk("hlen", 32'h1, {31'h0, rd inside {[32'd33:32'd37]}});
        apb(REG_STAT, 1'b1, 32'h0F);
        apb(REG_DIV, 1'b1, 32'h100);
        u_lsh_lin_master.bit_clk = 256;
        apb(REG_CTRL, 1'b1, 32'h1B);
        u_lsh_lin_master.send_bits(1'b0, 13);
        u_lsh_lin_master.send_bits(1'b1, 40);
        rdc(REG_STAT, 32'h0, "early timeout");
        bits(8);
        rdc(REG_STAT, 32'h1, "timeout");
        rdc(REG_CTRL, 32'h1B, "still mute");
        s0 = n_st;
        b0 = n_bt;
        repeat (256) @(posedge clk_sys);
        chk("sample ticks", 32'd16, n_st - s0);
        chk("bit ticks", 32'd1, n_bt - b0);
        apb(REG_STAT, 1'b1, 32'h0F);
        apb(REG_CTRL, 1'b1, 32'h23);
        apb(REG_DIV, 1'b1, 32'h104);
        rdc(REG_DIV, 32'h100, "div deferred");
        u_lsh_lin_master.send_char(8'hA5, 1'b1);
        u_lsh_lin_master.send_bits(1'b1, 1);
        rdc(REG_DIV, 32'h104, "div on char");
        rdc(REG_CTRL, 32'h03, "method cleared");
        rdc(REG_DATA, 32'hA5, "plain char");
        u_lsh_lin_master.send_char(8'h0F, 1'b0);
        u_lsh_lin_master.send_bits(1'b1, 2);
        rdc(REG_STAT, 32'h12, "framing error");
        report_and_stop();
    end
    // Watchdog
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        n_mismatch++;
        report_and_stop();
    end
endmodule // lsh_top_tb_top
